// ### design/cifm_freq_mon.sv
`timescale 1ns/1ps
module cifm_freq_mon #(
  parameter int CNT_W = cifm_pkg::CNT_W,
  parameter int WIN = cifm_pkg::WIN_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic i_mon_clk,
  input wire logic [CNT_W-1:0] i_lo_thr,
  input wire logic [CNT_W-1:0] i_hi_thr,
  output logic o_rise,
  output logic o_out_of_range
);
  localparam int ST = cifm_pkg::SYNC_LEN - 1;
  localparam int SM = cifm_pkg::SYNC_LEN - 2;
  localparam logic [CNT_W-1:0] WIN_LAST = CNT_W'(WIN - cifm_pkg::STEP);

  typedef struct packed {
    logic [cifm_pkg::SYNC_LEN-1:0] sync;
    logic filt;
    logic rise;
    logic [CNT_W-1:0] win;
    logic [CNT_W-1:0] edges;
    logic oor;
  } cifm_mon_s;

  cifm_mon_s s_r;
  cifm_mon_s s_nxt;
  logic agree;
  logic rise;
  logic [CNT_W-1:0] total;

  function automatic logic [CNT_W-1:0] sat_add(input logic [CNT_W-1:0] a, input logic b);
    logic [CNT_W:0] sum;
    sum = {1'b0, a} + {{CNT_W{1'b0}}, b};
    return sum[CNT_W] ? a : sum[CNT_W-1:0];
  endfunction : sat_add

  always_comb begin
    s_nxt = s_r;
    agree = s_r.sync[SM] == s_r.sync[ST];
    rise = agree && s_r.sync[ST] && !s_r.filt;
    total = sat_add(s_r.edges, rise);
    s_nxt.sync = {s_r.sync[SM:0], i_mon_clk};
    if (agree) begin
      s_nxt.filt = s_r.sync[ST];
    end
    s_nxt.rise = rise && i_en;
    if (!i_en) begin
      // Disabled monitor reports nothing
      s_nxt.win = '0;
      s_nxt.edges = '0;
      s_nxt.oor = 1'b0;
    end else if (s_r.win == WIN_LAST) begin
      s_nxt.win = '0;
      s_nxt.edges = '0;
      s_nxt.oor = (total < i_lo_thr) || (total > i_hi_thr);
    end else begin
      s_nxt.win = sat_add(s_r.win, 1'b1);
      s_nxt.edges = total;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rise = s_r.rise;
  assign o_out_of_range = s_r.oor;

  a_off_silent: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !i_en |=> !o_out_of_range)
    else $error("disabled monitor reports a fault");

  a_verdict_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_en && $past(i_en) && s_r.win != '0) |-> $stable(o_out_of_range))
    else $error("fault level changed between verdicts");

  a_thr_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_en && s_r.win == WIN_LAST && total < i_lo_thr) |=> o_out_of_range)
    else $error("count below low threshold not flagged");
endmodule : cifm_freq_mon

// ### design/cifm_top.sv
`timescale 1ns/1ps
// How it works
// - Two PLL supervisors: one for the system PLL, one for the peripheral PLL.
// - Each PLL loss-of-lock detection drives its own fault output line.
// - Reconfiguring a locked PLL, or its lock dropping, raises the loss-of-lock fault.
// - All frequency monitors start disabled and report nothing until enabled.
// - Crystal low when its count falls below RC window divided by 1 to 8.
// - Crystal missing (no rising edge for the dead time) also raises the crystal-low fault line.
// - System PLL output checked against low and high thresholds, own fault line.
// - Monitors 2,3,4,5,6 form the platform-clock fault line.
// - Monitors 7,8,9,10,11 form the other-clocks fault line.
// - A grouped fault line is the OR of its monitors' indications.
// - Software thresholds the running clock violates raise the out-of-range fault.
module cifm_top #(
  parameter int WIN_CYC = cifm_pkg::WIN_CYC,
  parameter int RELOCK_CYC = cifm_pkg::RELOCK_CYC,
  parameter int DEAD_CYC = cifm_pkg::DEAD_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [cifm_pkg::NUM_PLL-1:0] i_pll_en,
  input wire logic [cifm_pkg::NUM_PLL-1:0] i_pll_lock,
  input wire logic [cifm_pkg::NUM_PLL-1:0][cifm_pkg::CFG_W-1:0] i_pll_cfg,
  input wire logic [cifm_pkg::NUM_MON-1:0] i_mon_en,
  input wire logic [cifm_pkg::NUM_MON-1:0] i_mon_clk,
  input wire logic [cifm_pkg::NUM_MON-1:0][cifm_pkg::CNT_W-1:0] i_mon_lo_thr,
  input wire logic [cifm_pkg::NUM_MON-1:0][cifm_pkg::CNT_W-1:0] i_mon_hi_thr,
  input wire logic [cifm_pkg::XDIV_W-1:0] i_xtal_div,
  output logic [cifm_pkg::NUM_PLL-1:0] o_pll_lock_fault,
  output logic o_xtal_low_fault,
  output logic o_sys_clk_fault,
  output logic o_plat_clk_fault,
  output logic o_other_clk_fault,
  output logic [cifm_pkg::NUM_MON-1:0] o_mon_status
);
  localparam int NP = cifm_pkg::NUM_PLL;
  localparam int NM = cifm_pkg::NUM_MON;
  localparam int CW = cifm_pkg::CNT_W;
  localparam int ST = cifm_pkg::SYNC_LEN - 1;
  localparam int SM = cifm_pkg::SYNC_LEN - 2;
  localparam int XT = cifm_pkg::MON_XTAL;
  localparam int RL_W = $clog2(RELOCK_CYC + cifm_pkg::STEP);
  localparam int DEAD_W = $clog2(DEAD_CYC + cifm_pkg::STEP);
  localparam logic [RL_W-1:0] RL_LAST = RL_W'(RELOCK_CYC - cifm_pkg::STEP);
  localparam logic [RL_W-1:0] RL_ONE = RL_W'(cifm_pkg::STEP);
  localparam logic [DEAD_W-1:0] DEAD_LAST = DEAD_W'(DEAD_CYC - cifm_pkg::STEP);
  localparam logic [DEAD_W-1:0] DEAD_ONE = DEAD_W'(cifm_pkg::STEP);
  localparam logic [CW-1:0] THR_MAX = '1;

  typedef struct packed {
    logic [NP-1:0][cifm_pkg::SYNC_LEN-1:0] lsync;
    logic [NP-1:0] lock_f;
    logic [NP-1:0][cifm_pkg::CFG_W-1:0] cfg_q;
    cifm_pkg::cifm_pll_e [NP-1:0] pst;
    logic [NP-1:0][RL_W-1:0] rl_cnt;
    logic [NP-1:0] pll_fault;
    logic [DEAD_W-1:0] dead_cnt;
    logic dead;
    logic xtal;
    logic sys;
    logic plat;
    logic oth;
    logic [NM-1:0] stat;
  } cifm_top_s;

  cifm_top_s s_r;
  cifm_top_s s_nxt;
  logic [NP-1:0] cfg_chg;
  logic [NM-1:0] mon_oor;
  logic [NM-1:0] mon_rise;
  logic [CW-1:0] xtal_lo;

  // Smallest crystal count still at or above the RC window over the factor
  function automatic logic [CW-1:0] xtal_lo_thr(input logic [cifm_pkg::XDIV_W-1:0] div);
    int f;
    f = int'(div) + cifm_pkg::STEP;
    return CW'((WIN_CYC + f - cifm_pkg::STEP) / f);
  endfunction : xtal_lo_thr

  assign xtal_lo = xtal_lo_thr(i_xtal_div);

  genvar p;
  genvar k;

  generate
    for (p = 0; p < NP; p++) begin : g_chg
      assign cfg_chg[p] = i_pll_cfg[p] != s_r.cfg_q[p];
    end
  endgenerate

  generate
    for (k = 0; k < NM; k++) begin : g_mon
      logic [CW-1:0] lo;
      logic [CW-1:0] hi;
      if (k == XT) begin : g_xtal
        assign lo = xtal_lo;
        assign hi = THR_MAX;
      end else begin : g_thr
        assign lo = i_mon_lo_thr[k];
        assign hi = i_mon_hi_thr[k];
      end
      cifm_freq_mon #(
        .CNT_W(CW),
        .WIN(WIN_CYC)
      ) u_mon (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_en(i_mon_en[k]),
        .i_mon_clk(i_mon_clk[k]),
        .i_lo_thr(lo),
        .i_hi_thr(hi),
        .o_rise(mon_rise[k]),
        .o_out_of_range(mon_oor[k])
      );
    end
  endgenerate

  always_comb begin
    s_nxt = s_r;
    // One supervisor per PLL
    for (int i = 0; i < NP; i++) begin
      s_nxt.lsync[i] = {s_r.lsync[i][SM:0], i_pll_lock[i]};
      if (s_r.lsync[i][SM] == s_r.lsync[i][ST]) begin
        s_nxt.lock_f[i] = s_r.lsync[i][ST];
      end
      s_nxt.cfg_q[i] = i_pll_cfg[i];
      case (s_r.pst[i])
        cifm_pkg::PLL_OFF: begin
          s_nxt.pst[i] = cifm_pkg::PLL_ACQ;
        end
        cifm_pkg::PLL_ACQ: begin
          if (s_r.lock_f[i]) begin
            s_nxt.pst[i] = cifm_pkg::PLL_LOCK;
          end
        end
        cifm_pkg::PLL_LOCK: begin
          if (!s_r.lock_f[i] || cfg_chg[i]) begin
            s_nxt.pst[i] = cifm_pkg::PLL_LOST;
            s_nxt.rl_cnt[i] = '0;
          end
        end
        cifm_pkg::PLL_LOST: begin
          // Stay flagged until lock has been steady for the relock time
          if (s_r.lock_f[i] && !cfg_chg[i]) begin
            if (s_r.rl_cnt[i] == RL_LAST) begin
              s_nxt.pst[i] = cifm_pkg::PLL_LOCK;
            end else begin
              s_nxt.rl_cnt[i] = s_r.rl_cnt[i] + RL_ONE;
            end
          end else begin
            s_nxt.rl_cnt[i] = '0;
          end
        end
        default: begin
          s_nxt.pst[i] = cifm_pkg::PLL_OFF;
        end
      endcase
      if (!i_pll_en[i]) begin
        s_nxt.pst[i] = cifm_pkg::PLL_OFF;
        s_nxt.rl_cnt[i] = '0;
      end
      s_nxt.pll_fault[i] = s_nxt.pst[i] == cifm_pkg::PLL_LOST;
    end

    // Crystal edge watchdog catches a stopped crystal before a window ends
    if (!i_mon_en[XT] || mon_rise[XT]) begin
      s_nxt.dead_cnt = '0;
      s_nxt.dead = 1'b0;
    end else if (s_r.dead_cnt == DEAD_LAST) begin
      s_nxt.dead = 1'b1;
    end else begin
      s_nxt.dead_cnt = s_r.dead_cnt + DEAD_ONE;
    end

    s_nxt.stat = mon_oor;
    s_nxt.xtal = mon_oor[XT] || s_r.dead;
    s_nxt.sys = mon_oor[cifm_pkg::MON_SYS];
    s_nxt.plat = |mon_oor[cifm_pkg::PLAT_HI:cifm_pkg::PLAT_LO];
    s_nxt.oth = |mon_oor[cifm_pkg::OTH_HI:cifm_pkg::OTH_LO];
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_pll_lock_fault = s_r.pll_fault;
  assign o_xtal_low_fault = s_r.xtal;
  assign o_sys_clk_fault = s_r.sys;
  assign o_plat_clk_fault = s_r.plat;
  assign o_other_clk_fault = s_r.oth;
  assign o_mon_status = s_r.stat;

  generate
    for (p = 0; p < NP; p++) begin : g_pll_chk
      a_lock_drop: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (s_r.pst[p] == cifm_pkg::PLL_LOCK && i_pll_en[p] && !s_r.lock_f[p])
        |=> o_pll_lock_fault[p])
        else $error("lock drop not flagged");

      a_cfg_inject: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (s_r.pst[p] == cifm_pkg::PLL_LOCK && i_pll_en[p] && cfg_chg[p])
        |=> o_pll_lock_fault[p])
        else $error("running reconfiguration not flagged");

      a_pll_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_pll_en[p] |=> !o_pll_lock_fault[p])
        else $error("disabled pll shows a fault");

      a_relock_steady: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ($fell(o_pll_lock_fault[p]) && $past(i_pll_en[p]))
        |-> $past(s_r.lock_f[p], 2) && $past(s_r.lock_f[p], 4))
        else $error("fault cleared without steady relock");

      a_acq_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (s_r.pst[p] == cifm_pkg::PLL_OFF || s_r.pst[p] == cifm_pkg::PLL_ACQ)
        |=> !o_pll_lock_fault[p])
        else $error("never locked pll shows a fault");

      a_lost_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (o_pll_lock_fault[p] && i_pll_en[p] && (!s_r.lock_f[p] || cfg_chg[p]))
        |=> o_pll_lock_fault[p])
        else $error("lock fault dropped while cause persists");

      a_lock_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (s_r.pst[p] == cifm_pkg::PLL_LOCK && i_pll_en[p] && s_r.lock_f[p] && !cfg_chg[p])
        |=> !o_pll_lock_fault[p])
        else $error("steady locked pll shows a fault");
    end
  endgenerate

  generate
    for (k = 0; k < NM; k++) begin : g_mon_chk
      a_mon_disable: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_mon_en[k] |=> ##1 !o_mon_status[k])
        else $error("disabled monitor status set");

      a_status_copy: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        ##1 (o_mon_status[k] == $past(mon_oor[k])))
        else $error("monitor status not the registered flag");

      a_rise_gated: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !i_mon_en[k] |=> !mon_rise[k])
        else $error("disabled monitor passes clock edges");
    end
  endgenerate

  a_xtal_thr: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (int'(xtal_lo) * (int'(i_xtal_div) + 1) >= WIN_CYC) &&
    ((int'(xtal_lo) - 1) * (int'(i_xtal_div) + 1) < WIN_CYC))
    else $error("crystal threshold not window over factor");

  a_xtal_dead: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (s_r.dead_cnt == DEAD_LAST && i_mon_en[XT] && !mon_rise[XT])
    |=> ##1 o_xtal_low_fault)
    else $error("stopped crystal not flagged");

  a_xtal_line: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (mon_oor[XT] || s_r.dead) |=> o_xtal_low_fault)
    else $error("crystal fault line not raised");

  a_xtal_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!mon_oor[XT] && !s_r.dead) |=> !o_xtal_low_fault)
    else $error("crystal fault line raised without cause");

  a_dead_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!i_mon_en[XT] || mon_rise[XT]) |=> !s_r.dead && s_r.dead_cnt == '0)
    else $error("crystal watchdog not cleared by an edge");

  a_dead_count: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_mon_en[XT] && !mon_rise[XT] && s_r.dead_cnt != DEAD_LAST)
    |=> s_r.dead_cnt == $past(s_r.dead_cnt) + DEAD_ONE)
    else $error("crystal watchdog not counting");

  a_sys_line: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mon_oor[cifm_pkg::MON_SYS] |=> o_sys_clk_fault)
    else $error("system clock excursion not reported");

  a_sys_quiet: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !mon_oor[cifm_pkg::MON_SYS] |=> !o_sys_clk_fault)
    else $error("system clock fault without excursion");

  a_plat_group: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ##1 (o_plat_clk_fault == $past(|mon_oor[cifm_pkg::PLAT_HI:cifm_pkg::PLAT_LO])))
    else $error("platform fault line not the group OR");

  a_other_group: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ##1 (o_other_clk_fault == $past(|mon_oor[cifm_pkg::OTH_HI:cifm_pkg::OTH_LO])))
    else $error("other clocks fault line not the group OR");

  a_thr_violate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_mon_en[cifm_pkg::MON_SYS] && mon_oor[cifm_pkg::MON_SYS])
    |=> o_mon_status[cifm_pkg::MON_SYS] && o_sys_clk_fault)
    else $error("threshold violation not visible");
endmodule : cifm_top

// ### shared/cifm_pkg.sv
package cifm_pkg;
  localparam int NUM_PLL = 2;
  localparam int NUM_MON = 12;
  localparam int MON_XTAL = 0;
  localparam int MON_SYS = 1;
  localparam int PLAT_LO = 2;
  localparam int PLAT_HI = 6;
  localparam int OTH_LO = 7;
  localparam int OTH_HI = 11;
  localparam int CNT_W = 16;
  localparam int CFG_W = 8;
  localparam int XDIV_W = 3;
  localparam int SYNC_LEN = 3;
  localparam int STEP = 1;
  localparam int REF_PERIOD_NS = 40;
  localparam int WIN_TIME_NS = 10240;
  localparam int WIN_CYC = WIN_TIME_NS / REF_PERIOD_NS;
  localparam int RELOCK_TIME_NS = 1000;
  localparam int RELOCK_CYC = (RELOCK_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  localparam int DEAD_TIME_NS = 2000;
  localparam int DEAD_CYC = (DEAD_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
  typedef enum logic [1:0] {
    PLL_OFF = 2'h0,
    PLL_ACQ = 2'h1,
    PLL_LOCK = 2'h2,
    PLL_LOST = 2'h3
  } cifm_pll_e;
endpackage : cifm_pkg

// ### testbench/cifm_fault_collector_model.sv
`timescale 1ns/1ps
module cifm_fault_collector_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_clr,
  input wire logic [5:0] i_fault,
  output logic [5:0] o_seen
);
  // One sticky bit per dedicated fault input
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || i_clr) begin
      o_seen <= 6'h00;
    end else begin
      o_seen <= o_seen | i_fault;
    end
  end
endmodule : cifm_fault_collector_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int WIN = 64;
  localparam int RELOCK = 8;
  localparam int DEAD = 12;
  localparam int SETTLE = 2 * WIN + 8;
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_clr = 1'b0;
  logic [1:0] i_pll_en = '0;
  logic [1:0] i_pll_lock = '0;
  logic [1:0][7:0] i_pll_cfg = '0;
  logic [11:0] i_mon_en = '0;
  logic [11:0] i_mon_clk = '0;
  logic [11:0][15:0] i_mon_lo_thr;
  logic [11:0][15:0] i_mon_hi_thr;
  logic [2:0] i_xtal_div = 3'h7;
  logic [1:0] o_pll_lock_fault;
  logic o_xtal_low_fault, o_sys_clk_fault, o_plat_clk_fault, o_other_clk_fault;
  logic [11:0] o_mon_status;
  logic [5:0] faults, seen;
  logic [11:0] run = 12'hFFF;
  int cnt [12];
  int n_fail = 0;
  int cmp_count = 0;

  assign faults = {o_pll_lock_fault, o_xtal_low_fault, o_sys_clk_fault, o_plat_clk_fault, o_other_clk_fault};

  cifm_top #(.WIN_CYC(WIN), .RELOCK_CYC(RELOCK), .DEAD_CYC(DEAD)) cifm_top_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pll_en(i_pll_en), .i_pll_lock(i_pll_lock),
    .i_pll_cfg(i_pll_cfg), .i_mon_en(i_mon_en), .i_mon_clk(i_mon_clk), .i_mon_lo_thr(i_mon_lo_thr),
    .i_mon_hi_thr(i_mon_hi_thr), .i_xtal_div(i_xtal_div), .o_pll_lock_fault(o_pll_lock_fault),
    .o_xtal_low_fault(o_xtal_low_fault), .o_sys_clk_fault(o_sys_clk_fault),
    .o_plat_clk_fault(o_plat_clk_fault), .o_other_clk_fault(o_other_clk_fault), .o_mon_status(o_mon_status));

  cifm_fault_collector_model cifm_fault_collector_model_i (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_clr(i_clr), .i_fault(faults), .o_seen(seen));

  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  // Crystal toggles every 4 cycles: exactly 8 edges per window; others every 3
  always @(negedge i_ref_clk) begin
    for (int k = 0; k < 12; k++) begin
      if (run[k]) begin
        cnt[k] = cnt[k] + 1;
        if (cnt[k] >= ((k == 0) ? 4 : 3)) begin
          cnt[k] = 0;
          i_mon_clk[k] = ~i_mon_clk[k];
        end
      end
    end
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask : wait_cyc

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic results;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic set_thr(input int k, input logic [15:0] lo, input logic [15:0] hi);
    i_mon_lo_thr[k] = lo;
    i_mon_hi_thr[k] = hi;
  endtask : set_thr

  task automatic t_idle;
    for (int k = 1; k < 12; k++) set_thr(k, 16'h001E, 16'h0014);
    i_xtal_div = 3'h0;
    wait_cyc(3 * WIN);
    chk("status idle", 12'h000, o_mon_status);
    chk("faults idle", 12'h000, {6'h00, faults});
    chk("collector idle", 12'h000, {6'h00, seen});
    for (int k = 1; k < 12; k++) set_thr(k, 16'h0005, 16'h0014);
    i_xtal_div = 3'h7;
  endtask : t_idle

  task automatic t_groups;
    logic [5:0] exp;
    i_mon_en = 12'hFFF;
    wait_cyc(SETTLE);
    chk("status in range", 12'h000, o_mon_status);
    for (int k = 1; k < 12; k++) begin
      exp = {3'h0, k == 1, k >= 2 && k <= 6, k >= 7};
      if (k % 2 == 1) set_thr(k, 16'h001E, 16'h0014);
      else set_thr(k, 16'h0005, 16'h0004);
      wait_cyc(SETTLE);
      chk("status one", 12'h001 << k, o_mon_status);
      chk("group lines", {6'h00, exp}, {6'h00, faults});
      i_mon_en[k] = 1'b0;
      wait_cyc(3);
      chk("status off", 12'h000, o_mon_status);
      chk("group off", 12'h000, {6'h00, faults});
      set_thr(k, 16'h0005, 16'h0014);
      i_mon_en[k] = 1'b1;
      wait_cyc(SETTLE);
    end
    chk("collector groups", 12'h007, {6'h00, seen});
  endtask : t_groups

  task automatic t_xtal;
    for (int d = 0; d < 8; d++) begin
      i_xtal_div = 3'(d);
      wait_cyc(SETTLE);
      chk("xtal status", {11'h000, d < 7}, o_mon_status);
      chk("xtal fault", {11'h000, d < 7}, {11'h000, o_xtal_low_fault});
    end
    i_clr = 1'b1;
    wait_cyc(1);
    i_clr = 1'b0;
    run[0] = 1'b0;
    wait_cyc(DEAD + 8);
    chk("xtal stopped", 12'h001, {11'h000, o_xtal_low_fault});
    chk("collector xtal", 12'h008, {6'h00, seen});
    run[0] = 1'b1;
    wait_cyc(SETTLE);
    chk("xtal back", 12'h000, {11'h000, o_xtal_low_fault});
  endtask : t_xtal

  task automatic t_pll(input int n);
    i_pll_en[n] = 1'b1;
    wait_cyc(20);
    chk("pll unlocked", 12'h000, {10'h000, o_pll_lock_fault});
    i_pll_lock[n] = 1'b1;
    wait_cyc(12);
    chk("pll locked", 12'h000, {10'h000, o_pll_lock_fault});
    i_pll_cfg[n] = i_pll_cfg[n] + 8'h01;
    wait_cyc(3);
    chk("pll reconfig", 12'h001 << n, {10'h000, o_pll_lock_fault});
    wait_cyc(RELOCK + 6);
    chk("pll relock", 12'h000, {10'h000, o_pll_lock_fault});
    i_pll_lock[n] = 1'b0;
    wait_cyc(8);
    chk("pll drop", 12'h001 << n, {10'h000, o_pll_lock_fault});
    i_pll_en[n] = 1'b0;
    wait_cyc(3);
    chk("pll off", 12'h000, {10'h000, o_pll_lock_fault});
  endtask : t_pll

  initial begin
    for (int k = 0; k < 12; k++) begin
      set_thr(k, 16'h0005, 16'h0014);
    end
    wait_cyc(10);
    i_rst = 1'b0;
    wait_cyc(2);
    chk("reset faults", 12'h000, {6'h00, faults});
    t_idle();
    t_groups();
    t_xtal();
    t_pll(0);
    t_pll(1);
    chk("collector seen", 12'h038, {6'h00, seen});
    results();
  end

  initial begin
    wait_cyc(20000);
    n_fail++;
    results();
  end
endmodule : testbench
